/* File: mon_conv_model.sv */
module mon_conv_model (
    // clock
    input  wire         clk_i,
    // bench commands
    input  wire  [2:0]  ch_i,
    input  wire  [9:0]  val_i,
    input  wire         upd_i,
    input  wire         rd_i,
    // converter results and main bank reads
    output logic [79:0] conv_data_o = 80'h0,
    output logic [7:0]  conv_upd_o = 8'h0,
    output logic [7:0]  high_read_o = 8'h0
);
    timeunit 1ns;
    timeprecision 1ns;
    always @(posedge clk_i) begin
        conv_upd_o <= upd_i ? 8'h01 << ch_i : 8'h00;
        high_read_o <= rd_i ? 8'h01 << ch_i : 8'h00;
        // result register keeps its value between conversions
        if (upd_i) begin
            conv_data_o[ch_i*10 +: 10] <= val_i;
        end
    end
endmodule // mon_conv_model

/* File: mon_defs.vh */
`ifndef MON_DEFS_VH
`define MON_DEFS_VH

// register indices; byte address is four times the index
`define MON_IDX_LOW_A      8'h76
`define MON_IDX_LOW_B      8'h77
`define MON_IDX_CFG        8'h78
`define MON_IDX_PPR        8'h7b
`define MON_IDX_TEST_ONE   8'h7e
`define MON_IDX_TEST_TWO   8'h7f
`define MON_IDX_IRQ_STAT   8'h80
`define MON_IDX_IRQ_EN     8'h81
`define MON_IDX_IRQ_CLR    8'h82

// reset values
`define MON_CFG_RST        8'h00
`define MON_PPR_RST        8'h55
`define MON_TEST_RST       8'h00
`define MON_IRQ_RST        4'h0

// configuration field positions
`define MON_CFG_ALERT      0
`define MON_CFG_FAST       3
`define MON_CFG_CONT_LO    4
`define MON_CFG_CONT_HI    7

// interrupt status bits
`define MON_EV_REL_A       0
`define MON_EV_REL_B       1
`define MON_EV_TICK        2
`define MON_EV_LOCKED_WR   3

// channel layout
`define MON_CHANS          8
`define MON_GROUP          4
`define MON_READ_W         10

// measurement timing, 100 MHz clock
`define MON_CLK_HZ         100000000
`define MON_SLOW_MS        1000
`define MON_FAST_DIV       4
`define MON_TICK_W         27

`endif

/* File: mon_ext_regs.v */
`include "mon_defs.vh"

// Overview of operation
// - low register A: 2.5V, core, own, 5V
// - low register B: 12V, remote1, local, remote2
// - reading low register freezes group until read
// - config bit0 selects alert or fan two
// - config bit3 gives 250 ms fan rate
// - config bits 4..7 continuous fan measurement
// - config bits 1,2 reserved; resets to zero
// - 2-bit code selects 1 to 4 pulses
// - pulse count register resets to 0x55
// - lock set makes test registers read-only
module mon_ext_regs #(
    parameter SLOW_CYCLES = `MON_CLK_HZ / 1000 * `MON_SLOW_MS
) (
    // clock and reset
    input  wire        clk_i,
    input  wire        sys_rst_i,
    // apb slave
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [11:0] paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o,
    // conversions, channel n in bits 10n+9:10n
    input  wire [79:0] conv_data_i,
    input  wire [7:0]  conv_upd_i,
    // host reads of the high-byte registers, one pulse per channel
    input  wire [7:0]  high_read_i,
    // lock bit of the first configuration register
    input  wire        cfg_lock_i,
    // shared pin sources
    input  wire        out_of_limit_i,
    input  wire        fan_two_pulse_output_i,
    // held readings for the high-byte registers
    output wire [63:0] high_byte_o,
    output reg  [1:0]  frozen_o,
    // shared pin
    output reg         shared_pin_o,
    output reg         shared_pin_oe_o,
    // fan measurement control
    output reg         fan_meas_start_o,
    output reg  [3:0]  continuous_speed_o,
    output reg  [11:0] fan_pulses_o,
    // interrupt
    output reg         irq_o
);

    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_DONE = 2'b10;

    localparam [9:0] IX_LOW_A  = {2'h0, `MON_IDX_LOW_A};
    localparam [9:0] IX_LOW_B  = {2'h0, `MON_IDX_LOW_B};
    localparam [9:0] IX_CFG    = {2'h0, `MON_IDX_CFG};
    localparam [9:0] IX_PPR    = {2'h0, `MON_IDX_PPR};
    localparam [9:0] IX_TEST1  = {2'h0, `MON_IDX_TEST_ONE};
    localparam [9:0] IX_TEST2  = {2'h0, `MON_IDX_TEST_TWO};
    localparam [9:0] IX_STAT   = {2'h0, `MON_IDX_IRQ_STAT};
    localparam [9:0] IX_EN     = {2'h0, `MON_IDX_IRQ_EN};
    localparam [9:0] IX_CLR    = {2'h0, `MON_IDX_IRQ_CLR};

    reg  [1:0]  state;
    reg  [7:0]  pin_and_speed_config;
    reg  [7:0]  fan_pulse_count_select;
    reg  [7:0]  factory_test_one;
    reg  [7:0]  factory_test_two;
    reg  [3:0]  irq_status;
    reg  [3:0]  irq_enable;
    reg  [3:0]  seen_a;
    reg  [3:0]  seen_b;
    reg  [31:0] next_rdata;
    reg         next_err;
    reg  [3:0]  next_status;
    reg  [3:0]  next_seen_a;
    reg  [3:0]  next_seen_b;
    reg  [1:0]  next_frozen;
    reg  [3:0]  ev;

    wire [79:0] held;
    wire [7:0]  voltage_low_bits_a;
    wire [7:0]  voltage_temp_low_bits_b;
    wire        tick;

    wire [9:0] idx     = paddr_i[11:2];
    wire       aligned = paddr_i[1:0] == 2'b00;
    // effects only at the completing edge, never in the wait state
    wire       access  = psel_i && penable_i;
    wire       done    = access && pready_o;
    wire       wr      = done && pwrite_i && !pslverr_o;
    wire       rd      = done && !pwrite_i && !pslverr_o;
    wire       hold_a  = frozen_o[0];
    wire       hold_b  = frozen_o[1];

    // held readings, frozen per group while the host walks them
    genvar g;
    generate
        for (g = 0; g < `MON_CHANS; g = g + 1) begin : gen_chan
            mon_reading #(
                .W (`MON_READ_W)
            ) u_reading (
                .clk_i     (clk_i),
                .sys_rst_i (sys_rst_i),
                .upd_i     (conv_upd_i[g]),
                .data_i    (conv_data_i[10*g+9:10*g]),
                .hold_i    (g < `MON_GROUP ? hold_a : hold_b),
                .value_o   (held[10*g+9:10*g])
            );
            assign high_byte_o[8*g+7:8*g] = held[10*g+9:10*g+2];
        end
    endgenerate

    assign voltage_low_bits_a = {held[31:30], held[21:20],
                                 held[11:10], held[1:0]};
    assign voltage_temp_low_bits_b = {held[71:70], held[61:60],
                                      held[51:50], held[41:40]};

    mon_rate_tick #(
        .SLOW_CYCLES (SLOW_CYCLES),
        .FAST_DIV    (`MON_FAST_DIV),
        .CW          (`MON_TICK_W)
    ) u_rate (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .fast_i    (pin_and_speed_config[`MON_CFG_FAST]),
        .tick_o    (tick)
    );

    // read mux and address decode
    always @* begin
        next_rdata = 32'h0000_0000;
        next_err   = 1'b0;
        if (!aligned) begin
            next_err = 1'b1;
        end else begin
            case (idx)
                IX_LOW_A: begin
                    next_rdata[7:0] = voltage_low_bits_a;
                    next_err        = pwrite_i;
                end
                IX_LOW_B: begin
                    next_rdata[7:0] = voltage_temp_low_bits_b;
                    next_err        = pwrite_i;
                end
                IX_CFG:   next_rdata[7:0] = pin_and_speed_config;
                IX_PPR:   next_rdata[7:0] = fan_pulse_count_select;
                IX_TEST1: next_rdata[7:0] = factory_test_one;
                IX_TEST2: next_rdata[7:0] = factory_test_two;
                IX_STAT: begin
                    next_rdata[3:0] = irq_status;
                    next_err        = pwrite_i;
                end
                IX_EN:    next_rdata[3:0] = irq_enable;
                IX_CLR:   next_err = !pwrite_i;
                default:  next_err = 1'b1;
            endcase
        end
    end

    // one wait state: answer is prepared in the first access cycle
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            state     <= ST_IDLE;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (access) begin
                        state     <= ST_DONE;
                        pready_o  <= 1'b1;
                        pslverr_o <= next_err;
                        prdata_o  <= next_err ? 32'h0000_0000 : next_rdata;
                    end
                end
                ST_DONE: begin
                    state     <= ST_IDLE;
                    pready_o  <= 1'b0;
                    pslverr_o <= 1'b0;
                end
                default: begin
                    state    <= ST_IDLE;
                    pready_o <= 1'b0;
                end
            endcase
        end
    end

    // writable registers
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            pin_and_speed_config   <= `MON_CFG_RST;
            fan_pulse_count_select <= `MON_PPR_RST;
            factory_test_one       <= `MON_TEST_RST;
            factory_test_two       <= `MON_TEST_RST;
            irq_enable             <= `MON_IRQ_RST;
        end else if (wr) begin
            // locked test writes still answer okay; status logs the attempt
            case (idx)
                // reserved bits 1 and 2 simply store
                IX_CFG: pin_and_speed_config <= pwdata_i[7:0];
                IX_PPR: fan_pulse_count_select <= pwdata_i[7:0];
                IX_TEST1: begin
                    if (!cfg_lock_i) begin
                        factory_test_one <= pwdata_i[7:0];
                    end
                end
                IX_TEST2: begin
                    if (!cfg_lock_i) begin
                        factory_test_two <= pwdata_i[7:0];
                    end
                end
                IX_EN: irq_enable <= pwdata_i[3:0];
                default: irq_enable <= irq_enable;
            endcase
        end
    end

    // freeze tracking: a fresh low-register read restarts the walk
    always @* begin
        next_frozen = frozen_o;
        next_seen_a = seen_a | high_read_i[3:0];
        next_seen_b = seen_b | high_read_i[7:4];
        ev          = 4'h0;
        if (frozen_o[0] && next_seen_a == 4'hf) begin
            next_frozen[0]     = 1'b0;
            ev[`MON_EV_REL_A]  = 1'b1;
        end
        if (frozen_o[1] && next_seen_b == 4'hf) begin
            next_frozen[1]     = 1'b0;
            ev[`MON_EV_REL_B]  = 1'b1;
        end
        if (rd && idx == IX_LOW_A) begin
            next_frozen[0] = 1'b1;
            next_seen_a    = 4'h0;
        end
        if (rd && idx == IX_LOW_B) begin
            next_frozen[1] = 1'b1;
            next_seen_b    = 4'h0;
        end
        ev[`MON_EV_TICK] = tick;
        ev[`MON_EV_LOCKED_WR] = wr && cfg_lock_i &&
                                (idx == IX_TEST1 || idx == IX_TEST2);
        // set wins over a clear in the same cycle
        next_status = irq_status;
        if (wr && idx == IX_CLR) begin
            next_status = irq_status & ~pwdata_i[3:0];
        end
        next_status = next_status | ev;
    end

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            frozen_o   <= 2'b00;
            seen_a     <= 4'h0;
            seen_b     <= 4'h0;
            irq_status <= `MON_IRQ_RST;
            irq_o      <= 1'b0;
        end else begin
            frozen_o   <= next_frozen;
            seen_a     <= next_frozen[0] ? next_seen_a : 4'h0;
            seen_b     <= next_frozen[1] ? next_seen_b : 4'h0;
            irq_status <= next_status;
            // updated status used so the line rises with the event
            irq_o      <= |(next_status & irq_enable);
        end
    end

    // pin function and fan measurement control
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            shared_pin_o       <= 1'b0;
            shared_pin_oe_o    <= 1'b0;
            fan_meas_start_o   <= 1'b0;
            continuous_speed_o <= 4'h0;
            fan_pulses_o       <= 12'h000;
        end else begin
            if (pin_and_speed_config[`MON_CFG_ALERT]) begin
                // open-drain alert, active low
                shared_pin_o    <= 1'b0;
                shared_pin_oe_o <= out_of_limit_i;
            end else begin
                shared_pin_o    <= fan_two_pulse_output_i;
                shared_pin_oe_o <= 1'b1;
            end
            fan_meas_start_o   <= tick;
            continuous_speed_o <= pin_and_speed_config[`MON_CFG_CONT_HI:`MON_CFG_CONT_LO];
            fan_pulses_o <= {{1'b0, fan_pulse_count_select[7:6]} + 3'h1,
                             {1'b0, fan_pulse_count_select[5:4]} + 3'h1,
                             {1'b0, fan_pulse_count_select[3:2]} + 3'h1,
                             {1'b0, fan_pulse_count_select[1:0]} + 3'h1};
        end
    end

endmodule // mon_ext_regs

/* File: mon_ext_regs_assertions.sv */
module mon_chk (
    input wire        clk_i,
    input wire        sys_rst_i,
    input wire        psel_i,
    input wire        penable_i,
    input wire        pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [31:0] prdata_o,
    input wire        pready_o,
    input wire        pslverr_o,
    input wire [79:0] conv_data_i,
    input wire [7:0]  conv_upd_i,
    input wire [7:0]  high_read_i,
    input wire        fan_two_pulse_output_i,
    input wire [63:0] high_byte_o,
    input wire [1:0]  frozen_o,
    input wire        shared_pin_o,
    input wire        shared_pin_oe_o,
    input wire [3:0]  continuous_speed_o,
    input wire [11:0] fan_pulses_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    wire        done = psel_i && penable_i && pready_o;
    wire        wr_ok = done && pwrite_i && !pslverr_o;
    wire        rd_a = done && !pwrite_i && !pslverr_o && paddr_i == 12'h1d8;
    wire [11:0] ppr_exp = {{1'b0, pwdata_i[7:6]} + 3'h1, {1'b0, pwdata_i[5:4]} + 3'h1,
                           {1'b0, pwdata_i[3:2]} + 3'h1, {1'b0, pwdata_i[1:0]} + 3'h1};
    sequence s_first;
        psel_i && penable_i && !pready_o && !$past(penable_i);
    endsequence
    sequence s_frozen_upd;
        frozen_o[0] && conv_upd_i[0] && high_read_i == 8'h00;
    endsequence
    AST_WAIT: assert property (s_first |=> pready_o) else $error("access not answered after one wait");
    AST_PULSE: assert property (pready_o |=> !pready_o) else $error("ready longer than one cycle");
    AST_ERR: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0) else $error("bad error reply");
    AST_CONT: assert property (wr_ok && paddr_i == 12'h1e0 |-> ##2 continuous_speed_o == $past(pwdata_i[7:4], 2))
        else $error("continuous select wrong");
    AST_PPR: assert property (wr_ok && paddr_i == 12'h1ec |-> ##2 fan_pulses_o == $past(ppr_exp, 2))
        else $error("pulse count wrong");
    AST_FREEZE: assert property (rd_a |=> frozen_o[0]) else $error("group a not frozen");
    AST_HOLD: assert property (s_frozen_upd |=> $stable(high_byte_o[7:0])) else $error("frozen value moved");
    AST_TRACK: assert property (!frozen_o[0] && conv_upd_i[0] && !rd_a |=>
        high_byte_o[7:0] == $past(conv_data_i[9:2])) else $error("high byte not tracking");
    AST_PIN: assert property (shared_pin_o |-> shared_pin_oe_o && $past(fan_two_pulse_output_i))
        else $error("shared pin wrong");
endmodule // mon_chk
bind mon_ext_regs mon_chk u_chk (.clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .conv_data_i, .conv_upd_i, .high_read_i, .fan_two_pulse_output_i,
    .high_byte_o, .frozen_o, .shared_pin_o, .shared_pin_oe_o, .continuous_speed_o, .fan_pulses_o);

/* File: mon_rate_tick.v */
module mon_rate_tick #(
    parameter SLOW_CYCLES = 100000000,
    parameter FAST_DIV    = 4,
    parameter CW          = 27
) (
    // clock and reset
    input  wire clk_i,
    input  wire sys_rst_i,
    // rate select
    input  wire fast_i,
    // one pulse per measurement interval
    output reg  tick_o
);

    localparam integer  SLOW_M1   = SLOW_CYCLES - 1;
    localparam integer  FAST_M1   = SLOW_CYCLES / FAST_DIV - 1;
    localparam [CW-1:0] SLOW_LAST = SLOW_M1[CW-1:0];
    localparam [CW-1:0] FAST_LAST = FAST_M1[CW-1:0];

    reg  [CW-1:0] count;
    wire [CW-1:0] last = fast_i ? FAST_LAST : SLOW_LAST;

    // counter restarts from zero with a tick once it reaches or passes the end for the selected rate, so a slow-to-fast switch never runs long
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            count  <= {CW{1'b0}};
            tick_o <= 1'b0;
        end else if (count >= last) begin
            count  <= {CW{1'b0}};
            tick_o <= 1'b1;
        end else begin
            count  <= count + {{(CW-1){1'b0}}, 1'b1};
            tick_o <= 1'b0;
        end
    end

endmodule // mon_rate_tick

/* File: mon_reading.v */
module mon_reading #(
    parameter W = 10
) (
    // clock and reset
    input  wire         clk_i,
    input  wire         sys_rst_i,
    // conversion side
    input  wire         upd_i,
    input  wire [W-1:0] data_i,
    input  wire         hold_i,
    // held reading
    output reg  [W-1:0] value_o
);

    // whole 10-bit word taken at once so high and low parts match
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            value_o <= {W{1'b0}};
        end else if (upd_i && !hold_i) begin
            value_o <= data_i;
        end
    end

endmodule // mon_reading

/* File: tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SLOW = 400;
    logic        clk_i = 0;
    logic        sys_rst_i = 1;
    logic        psel_i = 0;
    logic        penable_i = 0;
    logic        pwrite_i = 0;
    logic [11:0] paddr_i = 0;
    logic [31:0] pwdata_i = 0;
    logic        cfg_lock_i = 0;
    logic        out_of_limit_i = 0;
    logic        fan_two_pulse_output_i = 0;
    logic [2:0]  ch = 0;
    logic [9:0]  val = 0;
    logic        upd = 0;
    logic        hrd = 0;
    logic [31:0] q;
    logic        e;
    logic [9:0]  ref_v [8];
    int          errors = 0;
    int          n_tests = 0;
    wire  [79:0] conv_data_i;
    wire  [7:0]  conv_upd_i, high_read_i;
    wire  [31:0] prdata_o;
    wire  [63:0] high_byte_o;
    wire  [11:0] fan_pulses_o;
    wire  [3:0]  continuous_speed_o;
    wire  [1:0]  frozen_o;
    wire         pready_o, pslverr_o, shared_pin_o, shared_pin_oe_o, fan_meas_start_o, irq_o;
    always #5 clk_i = ~clk_i;
    mon_conv_model u_conv (.clk_i, .ch_i(ch), .val_i(val), .upd_i(upd), .rd_i(hrd),
        .conv_data_o(conv_data_i), .conv_upd_o(conv_upd_i), .high_read_o(high_read_i));
    mon_ext_regs #(.SLOW_CYCLES(SLOW)) DUT (.clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .conv_data_i, .conv_upd_i, .high_read_i, .cfg_lock_i,
        .out_of_limit_i, .fan_two_pulse_output_i, .high_byte_o, .frozen_o, .shared_pin_o, .shared_pin_oe_o,
        .fan_meas_start_o, .continuous_speed_o, .fan_pulses_o, .irq_o);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk_i);
        psel_i <= 1;
        pwrite_i <= w;
        paddr_i <= {2'b00, idx, 2'b00};
        pwdata_i <= {24'h0, d};
        @(posedge clk_i);
        penable_i <= 1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        q = prdata_o;
        e = pslverr_o;
        psel_i <= 0;
        penable_i <= 0;
    endtask
    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
        apb(0, idx, 8'h00);
        chk(q, {24'h0, exp});
    endtask
    // conversion when u is set, otherwise a high-byte read of channel c
    task automatic pls(input logic u, input logic [2:0] c, input logic [9:0] v);
        @(posedge clk_i);
        ch <= c;
        val <= v;
        upd <= u;
        hrd <= !u;
        @(posedge clk_i);
        upd <= 0;
        hrd <= 0;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic gap(output int n);
        n = 0;
        while (fan_meas_start_o !== 1'b1 && n < 999) begin @(posedge clk_i); n++; end
        n = 0;
        do begin @(posedge clk_i); n++; end while (fan_meas_start_o !== 1'b1 && n < 999);
    endtask
    function automatic logic [7:0] lowexp(input int b);
        return {ref_v[b+3][1:0], ref_v[b+2][1:0], ref_v[b+1][1:0], ref_v[b][1:0]};
    endfunction
    function automatic logic [11:0] pexp(input logic [7:0] p);
        for (int f = 0; f < 4; f++) pexp[3*f +: 3] = {1'b0, p[2*f +: 2]} + 3'h1;
    endfunction
    task automatic stop_test;
        $display("comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #400000;
        errors++;
        stop_test;
    end
    initial begin
        logic [7:0] v;
        logic [1:0] r;
        int n;
        v = $urandom(32'h9898);
        repeat (12) @(posedge clk_i);
        sys_rst_i <= 0;
        repeat (2) @(posedge clk_i);
        chk(fan_pulses_o, 12'h492);
        rdchk(8'h78, 8'h00);
        rdchk(8'h7b, 8'h55);
        rdchk(8'h7e, 8'h00);
        rdchk(8'h7f, 8'h00);
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 8'hff : 8'($urandom);
            r = 2'($urandom);
            apb(1, 8'h78, v);
            out_of_limit_i <= r[0];
            fan_two_pulse_output_i <= r[1];
            rdchk(8'h78, v);
            chk(continuous_speed_o, v[7:4]);
            chk({shared_pin_o, shared_pin_oe_o}, v[0] ? {1'b0, r[0]} : {r[1], 1'b1});
        end
        for (int i = 0; i < 8; i++) begin
            v = (i < 4) ? {4{2'(i)}} : 8'($urandom);
            apb(1, 8'h7b, v);
            rdchk(8'h7b, v);
            chk(fan_pulses_o, pexp(v));
        end
        apb(1, 8'h78, 8'h08);
        gap(n);
        gap(n);
        chk(n, SLOW / 4);
        apb(1, 8'h78, 8'h00);
        gap(n);
        gap(n);
        chk(n, SLOW);
        apb(0, 8'h90, 8'h00);
        chk(e, 1);
        chk(q, 32'h0000_0000);
        apb(1, 8'h76, 8'hff);
        chk(e, 1);
        apb(1, 8'h7e, 8'ha5);
        rdchk(8'h7e, 8'ha5);
        apb(1, 8'h81, 8'h08);
        cfg_lock_i <= 1;
        apb(1, 8'h7f, 8'h3c);
        chk(e, 0);
        rdchk(8'h7f, 8'h00);
        apb(1, 8'h7e, 8'h5a);
        rdchk(8'h7e, 8'ha5);
        chk(irq_o, 1);
        apb(1, 8'h82, 8'h08);
        @(posedge clk_i);
        chk(irq_o, 0);
        apb(1, 8'h81, 8'h00);
        apb(1, 8'h7e, 8'h11);
        chk(irq_o, 0);
        apb(0, 8'h80, 8'h00);
        chk(q[3], 1);
        for (int c = 0; c < 8; c++) begin
            ref_v[c] = 10'($urandom);
            pls(1, 3'(c), ref_v[c]);
        end
        rdchk(8'h76, lowexp(0));
        rdchk(8'h77, lowexp(4));
        pls(1, 0, ~ref_v[0]);
        pls(1, 5, ~ref_v[5]);
        chk(high_byte_o[7:0], ref_v[0][9:2]);
        chk(high_byte_o[47:40], ref_v[5][9:2]);
        rdchk(8'h76, lowexp(0));
        for (int c = 3; c >= 0; c--) pls(0, 3'(c), 10'h0);
        chk(frozen_o, 2'b10);
        ref_v[0] = ~ref_v[0];
        pls(1, 0, ref_v[0]);
        chk(high_byte_o[7:0], ref_v[0][9:2]);
        rdchk(8'h76, lowexp(0));
        apb(0, 8'h80, 8'h00);
        chk(q, 32'h0000_000d);
        stop_test;
    end
endmodule // tb_top
